//--- design/chdb_card_dma.v
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "chdb_defines.vh"
module chdb_card_dma
(
    input  wire        clk,
    input  wire        sys_rst,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output wire        dmaReq,
    output reg         cmdStart,
    output reg  [5:0]  cmdIndex,
    output reg  [31:0] cmdArg,
    input  wire        cmdDone,
    input  wire        cardBusyPin,
    output wire        cardClkEn,
    output reg  [7:0]  cardTxData,
    output wire        cardTxValid,
    input  wire        cardTxReady,
    input  wire [7:0]  cardRxData,
    input  wire        cardRxValid
);

    // ****************************************
    // Registers and state
    // ****************************************
    reg [31:0] modeReg;
    reg [31:0] dmaCfg;
    reg [15:0] blockLen;
    reg        cmdReady;
    reg        xferDone;
    reg        overrun;
    reg        underrun;
    reg        xferActive;
    reg        xferWrite;
    reg        srcEnd;
    reg [15:0] byteCnt;
    reg [1:0]  lane;
    reg [31:0] fifoWord;
    reg        wordFull;
    reg [2:0]  busySync;
    reg        cardReleased;
    reg [7:0]  awAddr;
    reg        awHeld;
    reg [31:0] wData;
    reg [3:0]  wStrb;
    reg        wHeld;

    wire padSel   = modeReg[`CHDB_MODE_PAD_BIT];
    wire rdStop   = modeReg[`CHDB_MODE_RDSTOP];
    wire wrStop   = modeReg[`CHDB_MODE_WRSTOP];
    wire dma_handshake_enable    = dmaCfg[`CHDB_DMA_EN_BIT];
    wire [1:0] dmaOfs = dmaCfg[`CHDB_DMA_OFS_LSB+1:`CHDB_DMA_OFS_LSB];
    wire [7:0] padByte = padSel ? `CHDB_PAD_HIGH : `CHDB_PAD_LOW;

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    // Address and data are latched separately so either may arrive first
    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    wire doWrite = awHeld && wHeld && !s_axi_bvalid;
    wire doRead  = s_axi_arvalid && s_axi_arready;
    wire wrMode  = doWrite && (awAddr == `CHDB_MODE_ADDR);
    wire wrDma   = doWrite && (awAddr == `CHDB_DMACFG_ADDR);
    wire wrCmd   = doWrite && (awAddr == `CHDB_CMD_ADDR);
    wire wrArg   = doWrite && (awAddr == `CHDB_ARG_ADDR);
    wire wrCtrl  = doWrite && (awAddr == `CHDB_CTRL_ADDR);
    wire wrLen   = doWrite && (awAddr == `CHDB_BLKLEN_ADDR);
    wire wrFifo  = doWrite && (awAddr == `CHDB_FIFO_ADDR);
    wire rdFifo  = doRead && (s_axi_araddr == `CHDB_FIFO_ADDR);
    wire wrKnown = wrMode | wrDma | wrCmd | wrArg | wrCtrl | wrLen | wrFifo;

    // Byte-lane merge for word registers
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1)
                if (strb[i])
                    merge[i*8 +: 8] = nw[i*8 +: 8];
        end
    endfunction

    // Length register keeps only the low half of the merged word
    wire [31:0] lenMerged = merge({16'h0000, blockLen}, wData, wStrb);

    // Read mux; unmapped addresses answer SLVERR with zero data
    reg [31:0] next_rdata;
    reg        next_rerr;
    always @*
    begin
        next_rdata = 32'h0000_0000;
        next_rerr  = 1'b0;
        case (s_axi_araddr)
            `CHDB_MODE_ADDR:   next_rdata = modeReg;
            `CHDB_DMACFG_ADDR: next_rdata = dmaCfg;
            `CHDB_CMD_ADDR:    next_rdata = {18'h0_0000, cmdIndex, 6'h00, xferWrite,
                                             xferActive};
            `CHDB_ARG_ADDR:    next_rdata = cmdArg;
            `CHDB_STATUS_ADDR: next_rdata = {26'h000_0000, underrun, overrun, wordFull,
                                             xferDone, cardReleased, cmdReady};
            `CHDB_CTRL_ADDR:   next_rdata = {31'h0000_0000, srcEnd};
            `CHDB_BLKLEN_ADDR: next_rdata = {16'h0000, blockLen};
            `CHDB_FIFO_ADDR:   next_rdata = fifoWord;
            default:           next_rerr  = 1'b1;
        endcase
    end

    // Bus channel handshakes
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            awHeld       <= 1'b0;
            wHeld        <= 1'b0;
            awAddr       <= 8'h00;
            wData        <= 32'h0000_0000;
            wStrb        <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `CHDB_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `CHDB_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld <= 1'b1;
                awAddr <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            if (doWrite)
            begin
                awHeld       <= 1'b0;
                wHeld        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wrKnown ? `CHDB_RESP_OKAY : `CHDB_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (doRead)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= next_rdata;
                s_axi_rresp  <= next_rerr ? `CHDB_RESP_SLVERR : `CHDB_RESP_OKAY;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************
    // Card busy pin synchroniser
    // ****************************************
    // Stage 0 feeds stage 1 only; a change counts once stages 1 and 2 agree
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            busySync     <= 3'b000;
            cardReleased <= 1'b1;
        end
        else
        begin
            busySync <= {busySync[1:0], cardBusyPin};
            if (busySync[1] == busySync[2])
                cardReleased <= !busySync[2];
        end
    end

    // ****************************************
    // Data path between DMA and card
    // ****************************************
    wire lastByte = (byteCnt == blockLen - 16'h0001);
    wire padPhase = srcEnd && !wordFull;
    // Write side: a byte is ready from the word, or padding once the source is done
    assign cardTxValid = xferActive && xferWrite && (wordFull || padPhase) && cardClkEn;
    wire txTake = cardTxValid && cardTxReady;
    wire rxTake = xferActive && !xferWrite && cardRxValid && cardClkEn;
    // Read side: the word fills on lane 3 or on the last byte of the block
    wire rxFill = rxTake && !wordFull && (lane == 2'b11 || lastByte);

    // Request only in the direction that moves data
    assign dmaReq = dma_handshake_enable && xferActive &&
                    (xferWrite ? (!wordFull && !srcEnd) : wordFull);

    // Proof bits trade bandwidth for integrity by pausing the card clock
    assign cardClkEn = !(xferActive && ((!xferWrite && rdStop && wordFull) ||
                                        (xferWrite && wrStop && !wordFull && !srcEnd)));

    always @*
    begin
        cardTxData = wordFull ? fifoWord[lane*8 +: 8] : padByte;
    end

    // Transfer sequencing, FIFO word and flags
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            modeReg    <= `CHDB_MODE_RST;
            dmaCfg     <= `CHDB_DMACFG_RST;
            blockLen   <= `CHDB_BLKLEN_RST;
            cmdArg     <= 32'h0000_0000;
            cmdIndex   <= 6'h00;
            cmdStart   <= 1'b0;
            cmdReady   <= 1'b1;
            xferDone   <= 1'b0;
            overrun    <= 1'b0;
            underrun   <= 1'b0;
            xferActive <= 1'b0;
            xferWrite  <= 1'b0;
            srcEnd     <= 1'b0;
            byteCnt    <= 16'h0000;
            lane       <= 2'b00;
            fifoWord   <= 32'h0000_0000;
            wordFull   <= 1'b0;
        end
        else
        begin
            cmdStart <= wrCmd;
            if (wrMode)
                modeReg <= merge(modeReg, wData, wStrb);
            if (wrDma)
                dmaCfg <= merge(dmaCfg, wData, wStrb);
            if (wrLen)
                blockLen <= lenMerged[15:0];
            if (wrArg)
                cmdArg <= merge(cmdArg, wData, wStrb);
            if (wrCtrl && wData[`CHDB_CTRL_SRCEND])
                srcEnd <= 1'b1;
            // Command write starts a new command and, if a transfer with a nonzero block length, a new block
            if (wrCmd)
            begin
                cmdIndex <= wData[`CHDB_CMD_IDX_LSB+5:`CHDB_CMD_IDX_LSB];
                xferDone <= 1'b0;
                overrun  <= 1'b0;
                underrun <= 1'b0;
                if (wData[`CHDB_CMD_XFER_BIT] && blockLen != 16'h0000)
                begin
                    xferActive <= 1'b1;
                    xferWrite  <= wData[`CHDB_CMD_WR_BIT];
                    byteCnt    <= 16'h0000;
                    lane       <= wData[`CHDB_CMD_WR_BIT] ? dmaOfs : 2'b00;
                    wordFull   <= 1'b0;
                    srcEnd     <= 1'b0;
                end
            end
            // Ready drops on issue; completion set wins over the same-cycle clear
            if (cmdDone)
                cmdReady <= 1'b1;
            else if (wrCmd)
                cmdReady <= 1'b0;
            // DMA word moves through the FIFO window
            if (wrFifo && xferActive && xferWrite && !wordFull)
            begin
                fifoWord <= merge(fifoWord, wData, wStrb);
                wordFull <= 1'b1;
            end
            if (rdFifo && wordFull && xferActive && !xferWrite)
            begin
                wordFull <= 1'b0;
                if (byteCnt == blockLen)
                begin
                    xferActive <= 1'b0;
                    xferDone   <= 1'b1;
                end
            end
            // Card write side
            if (txTake)
            begin
                byteCnt <= byteCnt + 16'h0001;
                lane    <= lane + 2'b01;
                if (!wordFull)
                    underrun <= 1'b1;
                if (wordFull && (lane == 2'b11 || lastByte))
                    wordFull <= 1'b0;
                if (lastByte)
                begin
                    xferActive <= 1'b0;
                    xferDone   <= 1'b1;
                end
            end
            // Card read side; a byte that finds the word full is lost
            if (rxTake)
            begin
                if (wordFull)
                    overrun <= 1'b1;
                else
                begin
                    byteCnt <= byteCnt + 16'h0001;
                    lane    <= lane + 2'b01;
                    fifoWord[lane*8 +: 8] <= cardRxData;
                    if (lane == 2'b00)
                        fifoWord[31:8] <= 24'h00_0000;
                    if (rxFill)
                        wordFull <= 1'b1;
                end
            end
        end
    end

endmodule // chdb_card_dma
`default_nettype wire

//--- design/chdb_defines.vh
`ifndef CHDB_DEFINES_VH
`define CHDB_DEFINES_VH
// Register byte offsets
`define CHDB_MODE_ADDR      8'h00
`define CHDB_DMACFG_ADDR    8'h04
`define CHDB_CMD_ADDR       8'h08
`define CHDB_ARG_ADDR       8'h0C
`define CHDB_STATUS_ADDR    8'h10
`define CHDB_CTRL_ADDR      8'h14
`define CHDB_BLKLEN_ADDR    8'h18
`define CHDB_FIFO_ADDR      8'h20
// Mode register fields
`define CHDB_MODE_PAD_BIT   0
`define CHDB_MODE_RDSTOP    1
`define CHDB_MODE_WRSTOP    2
// DMA configuration fields
`define CHDB_DMA_OFS_LSB    0
`define CHDB_DMA_CHK_LSB    4
`define CHDB_DMA_EN_BIT     8
`define CHDB_DMA_READ_WORD_PAD_OPTION_BIT   12
// Command register fields
`define CHDB_CMD_XFER_BIT   0
`define CHDB_CMD_WR_BIT     1
`define CHDB_CMD_IDX_LSB    8
// Status register fields
`define CHDB_ST_COMMAND_READY_FLAG      0
`define CHDB_ST_RELEASED    1
`define CHDB_ST_DONE        2
`define CHDB_ST_FULL        3
`define CHDB_ST_OVERRUN     4
`define CHDB_ST_UNDERRUN    5
// Control register fields
`define CHDB_CTRL_SRCEND    0
// Reset values and pad bytes
`define CHDB_MODE_RST       32'h0000_0000
`define CHDB_DMACFG_RST     32'h0000_0000
`define CHDB_BLKLEN_RST     16'h0200
`define CHDB_PAD_LOW        8'h00
`define CHDB_PAD_HIGH       8'hFF
// AXI responses
`define CHDB_RESP_OKAY      2'b00
`define CHDB_RESP_SLVERR    2'b10
`endif

//--- verif/chdb_card_dma_assertions.sv
`timescale 1ns/10ps
`default_nettype none
`include "chdb_defines.vh"
// Bus answers and request pacing, seen at the pins
module chdb_card_dma_assertions (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic [7:0] s_axi_araddr,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       dmaReq,
    input wire logic       cmdStart
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Both write halves taken on one edge, and the word pushes and pops
    sequence wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence fifo_push;
        wr_both ##0 (s_axi_awaddr == `CHDB_FIFO_ADDR);
    endsequence
    sequence fifo_pop;
        s_axi_arvalid && s_axi_arready && (s_axi_araddr == `CHDB_FIFO_ADDR);
    endsequence
    // A reply stands alone: no new request is taken while it waits
    a_write_answer: assert property (wr_both |-> ##[1:2] s_axi_bvalid)
        else $error("late write reply");
    a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("address taken during reply");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("late read data");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during reply");
    // A command write launches exactly one start pulse
    a_cmd_launch: assert property (wr_both ##0 (s_axi_awaddr == `CHDB_CMD_ADDR) |-> ##[1:3] cmdStart)
        else $error("command not started");
    a_cmd_pulse: assert property (cmdStart |=> !cmdStart)
        else $error("start pulse too long");
    // The request falls once its word has moved
    a_req_wdrop: assert property (fifo_push ##0 dmaReq |-> ##[1:3] !dmaReq)
        else $error("write request stuck");
    a_req_rdrop: assert property (fifo_pop ##0 dmaReq |-> ##[1:2] !dmaReq)
        else $error("read request stuck");
endmodule // chdb_card_dma_assertions

bind chdb_card_dma chdb_card_dma_assertions i_chk (
    .clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .dmaReq(dmaReq),
    .cmdStart(cmdStart)
);
`default_nettype wire

//--- verif/chdb_card_model.sv
`timescale 1ns/10ps
`default_nettype none
// Card side: paces sent bytes, streams read bytes, ends commands
module chdb_card_model (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       rxGo,
    input wire logic       holdBusy,
    input wire logic       cmdStart,
    output logic           cmdDone,
    output logic           cardBusyPin,
    input wire logic       cardClkEn,
    input wire logic [7:0] cardTxData,
    input wire logic       cardTxValid,
    output logic           cardTxReady,
    output logic [7:0]     cardRxData,
    output logic           cardRxValid
);
    logic [7:0] txLog[$];
    logic [7:0] rxCnt = 8'h00;
    logic [2:0] tick = 3'h0;
    logic [2:0] cmdDly = 3'h0;
    // Busy only when the bench asks; one stalled cycle in eight makes a slow card
    assign cardBusyPin = holdBusy;
    assign cardTxReady = (tick != 3'h0);
    // Idle line shows the inverse so a stale byte never passes
    assign cardRxValid = rxGo && (rxCnt < 8'h08);
    assign cardRxData = cardRxValid ? 8'h10 + rxCnt : ~(8'h10 + rxCnt);
    // Bytes move only while the card clock runs
    always @(posedge clk)
    begin
        tick <= sys_rst ? 3'h0 : tick + 3'h1;
        cmdDly <= sys_rst ? 3'h0 : {cmdDly[1:0], cmdStart};
        cmdDone <= !sys_rst && cmdDly[2];
        rxCnt <= (sys_rst || !rxGo) ? 8'h00 : rxCnt + {7'h00, cardRxValid && cardClkEn};
        if (cardTxValid && cardTxReady)
            txLog.push_back(cardTxData);
    end
endmodule // chdb_card_model
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "chdb_defines.vh"
module tb_top;
    logic        clk, sys_rst, awV, wV, bRdy, bV, arV, arRdy, rRdy, rV, awRdy, wRdy;
    logic        dmaReq, cmdStart, cmdDone, busy, clkEn, txV, txR, rxV, rxGo, holdBusy;
    logic [7:0]  awA, arA, txD, rxD;
    logic [5:0]  cmdIdx;
    logic [31:0] wD, rD, d, cmdA;
    logic [1:0]  bR, rR, r;
    int          bad_count, n_compared, i, p;
    // Full strobes: every access is a whole word
    chdb_card_dma i_dut (
        .clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awA), .s_axi_awvalid(awV),
        .s_axi_awready(awRdy), .s_axi_wdata(wD), .s_axi_wstrb(4'hF), .s_axi_wvalid(wV),
        .s_axi_wready(wRdy), .s_axi_bresp(bR), .s_axi_bvalid(bV), .s_axi_bready(bRdy),
        .s_axi_araddr(arA), .s_axi_arvalid(arV), .s_axi_arready(arRdy), .s_axi_rdata(rD),
        .s_axi_rresp(rR), .s_axi_rvalid(rV), .s_axi_rready(rRdy), .dmaReq(dmaReq),
        .cmdStart(cmdStart), .cmdIndex(cmdIdx), .cmdArg(cmdA), .cmdDone(cmdDone),
        .cardBusyPin(busy),
        .cardClkEn(clkEn), .cardTxData(txD), .cardTxValid(txV), .cardTxReady(txR),
        .cardRxData(rxD), .cardRxValid(rxV)
    );
    chdb_card_model i_card (
        .clk(clk), .sys_rst(sys_rst), .rxGo(rxGo), .holdBusy(holdBusy),
        .cmdStart(cmdStart), .cmdDone(cmdDone),
        .cardBusyPin(busy), .cardClkEn(clkEn), .cardTxData(txD), .cardTxValid(txV),
        .cardTxReady(txR), .cardRxData(rxD), .cardRxValid(rxV)
    );
    // 250 MHz system clock
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Compare and count
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        bad_count += int'(g !== e);
        if (g !== e)
            $display("wrong value %s expected %h seen %h", nm, e, g);
    endtask
    // Write: each half released on the edge that takes it
    task wr(input logic [7:0] a, input logic [31:0] v);
        bit ad, wd;
        {ad, wd} = 2'b00;
        @(posedge clk);
        {awA, wD, awV, wV, bRdy} <= {a, v, 3'b111};
        while (!(ad && wd))
        begin
            @(posedge clk);
            {ad, wd} = {ad | awRdy, wd | wRdy};
            {awV, wV} <= {!ad, !wd};
        end
        do @(posedge clk); while (!bV);
        r = bR;
        bRdy <= 1'b0;
    endtask
    // Read: data and response taken on the rvalid edge
    task rd(input logic [7:0] a);
        @(posedge clk);
        {arA, arV, rRdy} <= {a, 2'b11};
        do @(posedge clk); while (!arRdy);
        arV <= 1'b0;
        do @(posedge clk); while (!rV);
        {d, r} = {rD, rR};
        rRdy <= 1'b0;
    endtask
    // Bounded waits for the request and for the done flag
    task waitReq;
        for (int n = 0; n < 500 && !dmaReq; n++) @(posedge clk);
        chk("dma request", 32'h1, dmaReq);
    endtask
    task waitDone;
        d = 32'h0;
        for (int n = 0; n < 200 && !d[`CHDB_ST_DONE]; n++) rd(`CHDB_STATUS_ADDR);
        chk("done flag", 32'h1, d[`CHDB_ST_DONE]);
    endtask
    task results;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Watchdog: far beyond the few hundred cycles the run needs
    initial
    begin
        #(4 * 20000);
        bad_count++;
        results;
    end
    // Reset, short padded writes with both pad bytes, then a two-word read
    initial
    begin
        sys_rst = 1'b1;
        {awV, wV, bRdy, arV, rRdy, rxGo, holdBusy} = 7'h00;
        {awA, arA, wD} = 48'h0000_0000_0000;
        {bad_count, n_compared} = 64'h0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rd(`CHDB_STATUS_ADDR);
        chk("ready flags", 32'h3, d[2:0]);
        // Busy pin must pass the synchroniser before the flag drops and returns
        holdBusy <= 1'b1;
        repeat (5) @(posedge clk);
        rd(`CHDB_STATUS_ADDR);
        chk("card released", 32'h0, d[`CHDB_ST_RELEASED]);
        holdBusy <= 1'b0;
        repeat (5) @(posedge clk);
        rd(`CHDB_STATUS_ADDR);
        chk("card released", 32'h1, d[`CHDB_ST_RELEASED]);
        rd(`CHDB_BLKLEN_ADDR);
        chk("block length", 32'h200, d);
        rd(8'hFC);
        chk("unmapped resp", `CHDB_RESP_SLVERR, r);
        for (p = 0; p < 2; p++)
        begin
            i_card.txLog.delete();
            wr(`CHDB_MODE_ADDR, 32'h4 | p);
            wr(`CHDB_BLKLEN_ADDR, 32'h6);
            wr(`CHDB_DMACFG_ADDR, 32'h10 | p);
            wr(`CHDB_ARG_ADDR, 32'h100 + p);
            wr(`CHDB_CMD_ADDR, 32'h1803);
            repeat (8) @(posedge clk);
            chk("early request", 32'h0, dmaReq);
            chk("command index", 32'h18, cmdIdx);
            chk("command argument", 32'h100 + p, cmdA);
            chk("write clock stop", 32'h0, clkEn);
            wr(`CHDB_DMACFG_ADDR, 32'h110 | p);
            waitReq;
            wr(`CHDB_FIFO_ADDR, 32'h4433_2211);
            wr(`CHDB_CTRL_ADDR, 32'h1);
            waitDone;
            chk("byte count", 32'h6, i_card.txLog.size());
            for (i = 0; i < 6; i++)
                chk("byte", (i + p < 4) ? 8'h11 * (i + p + 1) : {8{p[0]}}, i_card.txLog[i]);
        end
        wr(`CHDB_MODE_ADDR, 32'h2);
        wr(`CHDB_BLKLEN_ADDR, 32'h8);
        wr(`CHDB_DMACFG_ADDR, 32'h10);
        wr(`CHDB_CMD_ADDR, 32'h1101);
        wr(`CHDB_DMACFG_ADDR, 32'h110);
        chk("command index", 32'h11, cmdIdx);
        rxGo <= 1'b1;
        for (i = 0; i < 2; i++)
        begin
            waitReq;
            chk("read clock stop", 32'h0, clkEn);
            rd(`CHDB_FIFO_ADDR);
            chk("fifo word", 32'h1312_1110 + i * 32'h0404_0404, d);
        end
        waitDone;
        chk("overrun", 32'h0, d[`CHDB_ST_OVERRUN]);
        results;
    end
endmodule // tb_top
`default_nettype wire
